// File: rtl/edat_map.svh
// Summary of operation
// (RL1) Segment decode acts only on target read and fetch cycles.
// (RL2) Emulation data driven only on segment match and enabled 2K block.
// (RL3) No segment match leaves the bus to the target's own memory.
// (RL4) Segment value is four bits mapped bit by bit onto A16-A19.
// (RL5) Emulation memory is enabled in whole 2K-byte blocks.
// (RL6) Several segment and block pairs may be enabled together.
// (RL7) Latched upper address feeds both decode and trace control column.
// (RL8) Floating upper address inputs read as all ones.
// (RL9) Host loads a new segment only with a segment enable command.
// (RL10) Host programs a segment before enabling emulation memory.
// (RL11) Address trigger compares A0-A15 against the programmed value.
// (RL12) A 20-bit trigger extends the compare to A0-A19.
// (RL13) Range trigger matches lower to upper bound inclusive.
// (RL14) Address term may be inverted to match outside value or range.
// (RL15) New entry replaces old unless accumulated; accumulated entries OR. Here an accumulated entry also replaces old once all ENTRIES slots are full.
// (RL16) Accumulated entries match high and low bytes independently.
// (RL17) Address term is ANDed with the other trigger categories.
// (RL18) Address term evaluated once per captured bus cycle.
`ifndef EDAT_MAP_SVH
`define EDAT_MAP_SVH
`define EDAT_ADDR_SEG_ENA     12'h000
`define EDAT_ADDR_BLK_ENA     12'h004
`define EDAT_ADDR_TRG_CTRL    12'h008
`define EDAT_ADDR_TRG_LO      12'h00c
`define EDAT_ADDR_TRG_HI      12'h010
`define EDAT_ADDR_IRQ_STAT    12'h014
`define EDAT_ADDR_IRQ_MASK    12'h018
`define EDAT_ADDR_STATUS      12'h01c
`define EDAT_SEG_COUNT        4
`define EDAT_BLK_LSB          11
`define EDAT_BLK_MSB          15
`define EDAT_CTL_ACCUM        0
`define EDAT_CTL_RANGE        1
`define EDAT_CTL_INVERT       2
`define EDAT_CTL_WIDE         3
`define EDAT_CTL_CLEAR        4
`define EDAT_IRQ_TRIG         0
`define EDAT_IRQ_EMUL         1
`define EDAT_RESP_OKAY        2'h0
`define EDAT_RESP_SLVERR      2'h2
`endif

// File: rtl/edat_pkg.sv
package edat_pkg;
  typedef struct packed {
    logic [19:0] addr;
    logic        rd;
    logic        fetch;
    logic        strobe;
  } edat_cyc_t;
  typedef struct packed {
    logic [19:0] lo;
    logic [19:0] hi;
    logic        range;
    logic        invert;
    logic        wide;
  } edat_trg_t;
endpackage

// File: rtl/edat_top.sv
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "edat_map.svh"
module edat_top #(
  parameter int ENTRIES = 4
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  // AXI4-Lite write
  input  wire logic [11:0] awaddr_in,
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  input  wire logic        wvalid_in,
  output logic             wready_out,
  output logic [1:0]       bresp_out,
  output logic             bvalid_out,
  input  wire logic        bready_in,
  // AXI4-Lite read
  input  wire logic [11:0] araddr_in,
  input  wire logic        arvalid_in,
  output logic             arready_out,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  output logic             rvalid_out,
  input  wire logic        rready_in,
  // Target bus pins
  input  wire logic [19:0] tgt_addr_in,
  input  wire logic        tgt_rd_in,
  input  wire logic        tgt_fetch_in,
  input  wire logic        tgt_strobe_in,
  input  wire logic        other_terms_in,
  // Results
  output logic             emul_drive_out,
  output logic [3:0]       control_trace_column_out,
  output logic             trigger_out,
  output logic             irq_out
);
  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and strobe edge
  edat_pkg::edat_cyc_t s1_ff, s2_ff, nxt_s1, nxt_s2;
  logic strb_d_ff, nxt_strb_d;
  logic [19:0] lat_addr_ff, nxt_lat_addr;
  logic cyc_rd_ff, nxt_cyc_rd;
  logic cap_ff, nxt_cap;
  logic cyc_start;

  always_comb begin
    nxt_s1 = '{addr: tgt_addr_in, rd: tgt_rd_in, fetch: tgt_fetch_in,
               strobe: tgt_strobe_in};
    nxt_s2 = s1_ff;
    nxt_strb_d = s2_ff.strobe;
    cyc_start = s2_ff.strobe & ~strb_d_ff;
    nxt_lat_addr = lat_addr_ff;
    nxt_cyc_rd = cyc_rd_ff;
    nxt_cap = cyc_start;
    if (cyc_start) begin
      nxt_lat_addr = s2_ff.addr; // RL7 RL18
      nxt_cyc_rd = s2_ff.rd | s2_ff.fetch; // RL1
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s1_ff <= '{addr: 20'hfffff, rd: 1'b0, fetch: 1'b0, strobe: 1'b0};
      s2_ff <= '{addr: 20'hfffff, rd: 1'b0, fetch: 1'b0, strobe: 1'b0};
      strb_d_ff <= 1'b0;
      lat_addr_ff <= 20'hfffff; // RL8
      cyc_rd_ff <= 1'b0;
      cap_ff <= 1'b0;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
      strb_d_ff <= nxt_strb_d;
      lat_addr_ff <= nxt_lat_addr;
      cyc_rd_ff <= nxt_cyc_rd;
      cap_ff <= nxt_cap;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers
  logic [4*`EDAT_SEG_COUNT-1:0]  seg_ff, nxt_seg;
  logic [32*`EDAT_SEG_COUNT-1:0] blk_ff, nxt_blk;
  edat_pkg::edat_trg_t ent_ff [ENTRIES];
  edat_pkg::edat_trg_t nxt_ent [ENTRIES];
  logic [ENTRIES-1:0] ent_v_ff, nxt_ent_v;
  logic [19:0] lo_ff, nxt_lo, hi_ff, nxt_hi;
  logic [1:0] stat_ff, nxt_stat, mask_ff, nxt_mask;
  logic aw_ok, w_ok, do_wr;
  logic [11:0] aw_q_ff, nxt_aw_q;
  logic [31:0] w_q_ff, nxt_w_q;
  logic aw_h_ff, nxt_aw_h, w_h_ff, nxt_w_h, bv_ff, nxt_bv;
  logic [1:0] br_ff, nxt_br;
  logic [11:0] wa;
  logic [31:0] wd;
  logic emul_hit, trg_hit, addr_term;
  logic [$clog2(ENTRIES+1)-1:0] fill;

  // Each segment slot owns a 32-bit block-enable word in blk_ff, indexed by address bits [15:11]
  always_comb begin
    emul_hit = 1'b0;
    for (int i = 0; i < `EDAT_SEG_COUNT; i++) begin
      if (seg_ff[4*i +: 4] == lat_addr_ff[19:16] &&
          blk_ff[32*i + 32'(lat_addr_ff[`EDAT_BLK_MSB:`EDAT_BLK_LSB])])
        emul_hit = 1'b1; // RL2 RL3 RL4 RL5 RL6
    end
  end
  assign emul_drive_out = cyc_rd_ff & emul_hit; // RL1 RL2 RL3
  assign control_trace_column_out = lat_addr_ff[19:16]; // RL7

  edat_trig_cmp #(.ENTRIES(ENTRIES)) u_cmp (
    .ent_in   (ent_ff),
    .valid_in (ent_v_ff),
    .addr_in  (lat_addr_ff),
    .match_out(addr_term)
  );
  assign trg_hit = cap_ff & addr_term & other_terms_in; // RL17 RL18
  assign trigger_out = trg_hit;

  always_comb begin
    fill = '0;
    for (int i = 0; i < ENTRIES; i++)
      fill = fill + {{($bits(fill)-1){1'b0}}, ent_v_ff[i]};
  end

  assign aw_ok = awvalid_in & ~aw_h_ff & ~bv_ff;
  assign w_ok = wvalid_in & ~w_h_ff & ~bv_ff;
  assign awready_out = ~aw_h_ff & ~bv_ff;
  assign wready_out = ~w_h_ff & ~bv_ff;
  assign wa = aw_h_ff ? aw_q_ff : awaddr_in;
  assign wd = w_h_ff ? w_q_ff : wdata_in;
  assign do_wr = (aw_h_ff | aw_ok) & (w_h_ff | w_ok);
  assign bvalid_out = bv_ff;
  assign bresp_out = br_ff;

  always_comb begin
    nxt_seg = seg_ff;
    nxt_blk = blk_ff;
    nxt_ent = ent_ff;
    nxt_ent_v = ent_v_ff;
    nxt_lo = lo_ff;
    nxt_hi = hi_ff;
    nxt_mask = mask_ff;
    nxt_aw_q = aw_ok ? awaddr_in : aw_q_ff;
    nxt_w_q = w_ok ? wdata_in : w_q_ff;
    nxt_aw_h = (aw_h_ff | aw_ok) & ~do_wr;
    nxt_w_h = (w_h_ff | w_ok) & ~do_wr;
    nxt_bv = do_wr | (bv_ff & ~bready_in);
    nxt_br = br_ff;
    nxt_stat = stat_ff;
    if (do_wr) begin
      nxt_br = `EDAT_RESP_OKAY;
      unique case (wa)
        `EDAT_ADDR_SEG_ENA: nxt_seg[4*wd[5:4] +: 4] = wd[3:0]; // RL4 RL9
        `EDAT_ADDR_BLK_ENA: begin
          nxt_blk[32*wd[17:16] +: 32] = {16'h0, wd[15:0]}; // RL5 RL6
        end
        `EDAT_ADDR_TRG_LO: nxt_lo = wd[19:0];
        `EDAT_ADDR_TRG_HI: nxt_hi = wd[19:0];
        `EDAT_ADDR_TRG_CTRL: begin
          if (wd[`EDAT_CTL_CLEAR]) begin
            nxt_ent_v = '0;
          end else begin
            if (!wd[`EDAT_CTL_ACCUM] || fill == ENTRIES[$bits(fill)-1:0])
              nxt_ent_v = '0; // RL15
            for (int i = ENTRIES-1; i >= 0; i--)
              if (!nxt_ent_v[i]) begin
                nxt_ent[i] = '{lo: lo_ff, hi: hi_ff,
                  range: wd[`EDAT_CTL_RANGE], invert: wd[`EDAT_CTL_INVERT],
                  wide: wd[`EDAT_CTL_WIDE]}; // RL12 RL13 RL14
              end
            for (int i = 0; i < ENTRIES; i++)
              if (!nxt_ent_v[i] && (i == 0 || nxt_ent_v[(i > 0) ? i-1 : 0] ||
                  (!wd[`EDAT_CTL_ACCUM]))) begin
                nxt_ent_v[i] = 1'b1;
                break;
              end
          end
        end
        `EDAT_ADDR_IRQ_STAT: nxt_stat = stat_ff & ~wd[1:0];
        `EDAT_ADDR_IRQ_MASK: nxt_mask = wd[1:0];
        default: nxt_br = `EDAT_RESP_SLVERR;
      endcase
    end
    // Set wins over clear
    if (trg_hit) nxt_stat[`EDAT_IRQ_TRIG] = 1'b1;
    if (cap_ff & emul_drive_out) nxt_stat[`EDAT_IRQ_EMUL] = 1'b1;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      seg_ff <= '1;
      blk_ff <= '0;
      for (int i = 0; i < ENTRIES; i++) ent_ff[i] <= '0;
      ent_v_ff <= '0;
      lo_ff <= 20'h00000;
      hi_ff <= 20'h00000;
      stat_ff <= 2'h0;
      mask_ff <= 2'h0;
      aw_q_ff <= 12'h000;
      w_q_ff <= 32'h0;
      aw_h_ff <= 1'b0;
      w_h_ff <= 1'b0;
      bv_ff <= 1'b0;
      br_ff <= 2'h0;
    end else begin
      seg_ff <= nxt_seg;
      blk_ff <= nxt_blk;
      ent_ff <= nxt_ent;
      ent_v_ff <= nxt_ent_v;
      lo_ff <= nxt_lo;
      hi_ff <= nxt_hi;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      aw_q_ff <= nxt_aw_q;
      w_q_ff <= nxt_w_q;
      aw_h_ff <= nxt_aw_h;
      w_h_ff <= nxt_w_h;
      bv_ff <= nxt_bv;
      br_ff <= nxt_br;
    end
  end
  assign irq_out = |(stat_ff & mask_ff);

  //////////////////////////////////////////////////////////////////////////
  // Read channel
  logic rv_ff, nxt_rv;
  logic [31:0] rd_ff, nxt_rd;
  logic [1:0] rr_ff, nxt_rr;
  assign arready_out = ~rv_ff;
  assign rvalid_out = rv_ff;
  assign rdata_out = rd_ff;
  assign rresp_out = rr_ff;

  always_comb begin
    nxt_rv = rv_ff & ~rready_in;
    nxt_rd = rd_ff;
    nxt_rr = rr_ff;
    if (arvalid_in & ~rv_ff) begin
      nxt_rv = 1'b1;
      nxt_rr = `EDAT_RESP_OKAY;
      nxt_rd = 32'h0;
      unique case (araddr_in)
        `EDAT_ADDR_SEG_ENA: nxt_rd = {16'h0, seg_ff};
        `EDAT_ADDR_BLK_ENA: nxt_rd = blk_ff[31:0];
        `EDAT_ADDR_TRG_LO: nxt_rd = {12'h0, lo_ff};
        `EDAT_ADDR_TRG_HI: nxt_rd = {12'h0, hi_ff};
        `EDAT_ADDR_TRG_CTRL: nxt_rd = {{(32-ENTRIES){1'b0}}, ent_v_ff};
        `EDAT_ADDR_IRQ_STAT: nxt_rd = {30'h0, stat_ff};
        `EDAT_ADDR_IRQ_MASK: nxt_rd = {30'h0, mask_ff};
        `EDAT_ADDR_STATUS: nxt_rd = {12'h0, lat_addr_ff}; // RL7
        default: nxt_rr = `EDAT_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rv_ff <= 1'b0;
      rd_ff <= 32'h0;
      rr_ff <= 2'h0;
    end else begin
      rv_ff <= nxt_rv;
      rd_ff <= nxt_rd;
      rr_ff <= nxt_rr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  a_emul_only_read: assert property ( // RL1
    @(posedge clk_in) disable iff (srst_in)
    cap_ff && emul_drive_out |-> $past(s2_ff.rd | s2_ff.fetch))
    else $error("emul on non-read");
  a_emul_seg_match: assert property ( // RL3
    @(posedge clk_in) disable iff (srst_in)
    emul_drive_out |-> (seg_ff[3:0] == control_trace_column_out) ||
      (seg_ff[7:4] == control_trace_column_out) ||
      (seg_ff[11:8] == control_trace_column_out) ||
      (seg_ff[15:12] == control_trace_column_out))
    else $error("emul without match");
  a_trace_column: assert property ( // RL7
    @(posedge clk_in) disable iff (srst_in)
    cyc_start |=> control_trace_column_out == $past(s2_ff.addr[19:16]))
    else $error("trace column not latched");
  a_float_high: assert property ( // RL8
    @(posedge clk_in) disable iff (srst_in)
    $fell(srst_in) |-> control_trace_column_out == 4'hf)
    else $error("latched segment not all ones");
  a_trig_and_terms: assert property ( // RL17
    @(posedge clk_in) disable iff (srst_in)
    trigger_out |-> other_terms_in && addr_term)
    else $error("trigger without all terms");
  a_trig_per_cycle: assert property ( // RL18
    @(posedge clk_in) disable iff (srst_in)
    trigger_out |=> !trigger_out) else $error("trigger twice");
  a_trig_sticky: assert property (@(posedge clk_in) disable iff (srst_in)
    trigger_out |=> stat_ff[`EDAT_IRQ_TRIG]) else $error("trig not sticky");
  a_bresp_after: assert property (@(posedge clk_in) disable iff (srst_in)
    do_wr |=> bvalid_out) else $error("no write response");
  a_rd_answer: assert property (@(posedge clk_in) disable iff (srst_in)
    arvalid_in && arready_out |=> rvalid_out) else $error("no read answer");
  c_emul: cover property (@(posedge clk_in) emul_drive_out);
  c_trig: cover property (@(posedge clk_in) trigger_out);
  c_irq: cover property (@(posedge clk_in) irq_out);
  c_accum_trig: cover property (@(posedge clk_in) trigger_out && ent_v_ff[1]);
  c_range_trig: cover property (@(posedge clk_in) trigger_out && ent_ff[0].range);
endmodule // edat_top

// File: rtl/edat_trig_cmp.sv
`timescale 1ns/1ps
`include "edat_map.svh"
module edat_trig_cmp #(
  parameter int ENTRIES = 4
) (
  // Entries
  input  wire edat_pkg::edat_trg_t     ent_in [ENTRIES],
  input  wire logic [ENTRIES-1:0]      valid_in,
  // Sample
  input  wire logic [19:0]             addr_in,
  // Result
  output logic                         match_out
);
  function automatic logic in_range(input logic [19:0] a,
      input logic [19:0] l, input logic [19:0] h);
    in_range = (a >= l) && (a <= h); // RL13
  endfunction

  logic hi_any;
  logic lo_any;
  logic rng_any;
  logic inv;

  // Bytes of all accumulated non-range entries match independently
  always_comb begin
    hi_any  = 1'b0;
    lo_any  = 1'b0;
    rng_any = 1'b0;
    inv     = 1'b0;
    for (int i = 0; i < ENTRIES; i++) begin
      if (valid_in[i]) begin
        inv = inv | ent_in[i].invert;
        if (ent_in[i].range) begin
          rng_any = rng_any | (ent_in[i].wide ?
            in_range(addr_in, ent_in[i].lo, ent_in[i].hi) :
            in_range({4'h0, addr_in[15:0]}, {4'h0, ent_in[i].lo[15:0]},
                     {4'h0, ent_in[i].hi[15:0]})); // RL12
        end else begin
          hi_any = hi_any | ((addr_in[15:8] == ent_in[i].lo[15:8]) &&
            (!ent_in[i].wide ||
             addr_in[19:16] == ent_in[i].lo[19:16])); // RL11 RL12 RL16
          lo_any = lo_any | (addr_in[7:0] == ent_in[i].lo[7:0]); // RL16
        end
      end
    end
    match_out = ((hi_any & lo_any) | rng_any) ^ inv; // RL14 RL15
  end
endmodule // edat_trig_cmp

// File: tb/edat_tgt_model.sv
`timescale 1ns/1ps
module edat_tgt_model (
  // Clock
  input  wire logic        clk_in,
  // Cycle request
  input  wire logic        go_in,
  input  wire logic [19:0] addr_in,
  input  wire logic        rd_in,
  input  wire logic        fetch_in,
  // Target pins
  output logic [19:0]      tgt_addr_out,
  output logic             tgt_rd_out,
  output logic             tgt_fetch_out,
  output logic             tgt_strobe_out,
  output logic             done_out
);
  int cnt;
  initial begin
    cnt = 0;
    tgt_addr_out = 20'h0;
    tgt_rd_out = 1'b0;
    tgt_fetch_out = 1'b0;
    tgt_strobe_out = 1'b0;
    done_out = 1'b0;
  end
  // Address and type lead the strobe by one cycle
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (cnt == 0 && go_in) begin
      tgt_addr_out <= addr_in;
      tgt_rd_out <= rd_in;
      tgt_fetch_out <= fetch_in;
      cnt <= 1;
    end else if (cnt == 1) begin
      tgt_strobe_out <= 1'b1;
      cnt <= 2;
    end else if (cnt >= 2 && cnt < 12) begin
      cnt <= cnt + 1;
    end else if (cnt == 12) begin
      // Released address lines show the inverse, never the old value
      tgt_strobe_out <= 1'b0;
      tgt_addr_out <= ~tgt_addr_out;
      done_out <= 1'b1;
      cnt <= 0;
    end
  end
endmodule // edat_tgt_model

// File: tb/tb.sv
`timescale 1ns/1ps
`include "edat_map.svh"
module tb;
  logic        clk_in, srst_in, awvalid, wvalid, arvalid, bready, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [19:0] t_addr, m_addr;
  logic        t_rd, t_fetch, t_stb, m_rd, m_fetch, go, done, other;
  logic        emul, trg, irq, emul_seen;
  logic [3:0]  col;
  int          num_errors, n_compared, trg_cnt;
  localparam logic [1:0] OK = `EDAT_RESP_OKAY;
  edat_top #(.ENTRIES(4)) dut_u (
    .clk_in(clk_in), .srst_in(srst_in),
    .awaddr_in(awaddr), .awvalid_in(awvalid), .awready_out(awready),
    .wdata_in(wdata), .wstrb_in(4'hf), .wvalid_in(wvalid),
    .wready_out(wready), .bresp_out(bresp), .bvalid_out(bvalid),
    .bready_in(bready), .araddr_in(araddr), .arvalid_in(arvalid),
    .arready_out(arready), .rdata_out(rdata), .rresp_out(rresp),
    .rvalid_out(rvalid), .rready_in(rready),
    .tgt_addr_in(t_addr), .tgt_rd_in(t_rd), .tgt_fetch_in(t_fetch),
    .tgt_strobe_in(t_stb), .other_terms_in(other),
    .emul_drive_out(emul), .control_trace_column_out(col),
    .trigger_out(trg), .irq_out(irq));
  edat_tgt_model tgt_u (
    .clk_in(clk_in), .go_in(go), .addr_in(m_addr), .rd_in(m_rd),
    .fetch_in(m_fetch), .tgt_addr_out(t_addr), .tgt_rd_out(t_rd),
    .tgt_fetch_out(t_fetch), .tgt_strobe_out(t_stb), .done_out(done));
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    if (t_stb) emul_seen <= emul;
    if (trg === 1'b1) trg_cnt <= trg_cnt + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo;
    num_errors++;
    $display("wait ran out at %0t", $time);
    finish_test();
  endtask
  task axi_wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tr;
    logic [1:0] rs;
    int i;
    @(posedge clk_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(negedge clk_in);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tr = bvalid;
      rs = bresp;
      @(posedge clk_in);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr) break;
    end
    if (i == 64) tmo();
    chk({30'h0, rs}, {30'h0, OK});
  endtask
  task axi_rd(input logic [11:0] a, input logic [31:0] ed,
              input logic [1:0] er);
    logic ta, tr;
    logic [1:0] rs;
    logic [31:0] rd;
    int i;
    @(posedge clk_in);
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 64; i++) begin
      @(negedge clk_in);
      ta = arvalid & arready;
      tr = rvalid;
      rs = rresp;
      rd = rdata;
      @(posedge clk_in);
      if (ta) arvalid <= 1'b0;
      if (tr) break;
    end
    if (i == 64) tmo();
    chk(rd, ed);
    chk({30'h0, rs}, {30'h0, er});
  endtask
  task cyc(input logic [19:0] a, input logic r, input logic f,
           input logic o, input logic ee, input int et);
    int i, c0;
    @(posedge clk_in);
    m_addr <= a;
    m_rd <= r;
    m_fetch <= f;
    other <= o;
    go <= 1'b1;
    c0 = trg_cnt;
    @(posedge clk_in);
    go <= 1'b0;
    for (i = 0; i < 40; i++) begin
      @(negedge clk_in);
      if (done === 1'b1) break;
    end
    if (i == 40) tmo();
    @(posedge clk_in);
    chk({31'h0, emul_seen}, {31'h0, ee});
    chk(trg_cnt - c0, et);
    chk({28'h0, col}, {28'h0, a[19:16]});
  endtask
  task trg_set(input logic [31:0] c, input logic [19:0] l,
               input logic [19:0] h);
    axi_wr(`EDAT_ADDR_TRG_LO, {12'h0, l});
    axi_wr(`EDAT_ADDR_TRG_HI, {12'h0, h});
    axi_wr(`EDAT_ADDR_TRG_CTRL, c);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {srst_in, bready, rready, other} = 4'hf;
    {awvalid, wvalid, arvalid, go, m_rd, m_fetch, emul_seen} = 7'h0;
    {awaddr, araddr, wdata, m_addr} = 76'h0;
    {num_errors, n_compared, trg_cnt} = 96'h0;
    repeat (20) @(posedge clk_in);
    srst_in <= 1'b0;
    @(posedge clk_in);
    chk({28'h0, col}, 32'hf);
    axi_rd(`EDAT_ADDR_STATUS, 32'hfffff, OK);
    axi_rd(`EDAT_ADDR_SEG_ENA, 32'hffff, OK);
    axi_rd(12'h100, 32'h0, `EDAT_RESP_SLVERR);
    $display("test reset done");
    axi_wr(`EDAT_ADDR_SEG_ENA, 32'h7);
    axi_wr(`EDAT_ADDR_BLK_ENA, 32'h1);
    cyc(20'h70010, 1'b1, 1'b0, 1'b1, 1'b1, 0);
    cyc(20'h707ff, 1'b0, 1'b1, 1'b1, 1'b1, 0);
    cyc(20'h70800, 1'b1, 1'b0, 1'b1, 1'b0, 0);
    cyc(20'h70000, 1'b0, 1'b0, 1'b1, 1'b0, 0);
    cyc(20'hf0000, 1'b1, 1'b0, 1'b1, 1'b0, 0);
    cyc(20'h80000, 1'b0, 1'b1, 1'b1, 1'b0, 0);
    $display("test decode done");
    axi_wr(`EDAT_ADDR_SEG_ENA, 32'h0f);
    axi_wr(`EDAT_ADDR_SEG_ENA, 32'h1e);
    axi_wr(`EDAT_ADDR_BLK_ENA, 32'h00001);
    axi_wr(`EDAT_ADDR_BLK_ENA, 32'h10001);
    axi_rd(`EDAT_ADDR_SEG_ENA, 32'hffef, OK);
    cyc(20'he0000, 1'b1, 1'b0, 1'b1, 1'b1, 0);
    cyc(20'hf07ff, 1'b1, 1'b0, 1'b1, 1'b1, 0);
    cyc(20'he0800, 1'b1, 1'b0, 1'b1, 1'b0, 0);
    cyc(20'h70000, 1'b1, 1'b0, 1'b1, 1'b0, 0);
    axi_rd(`EDAT_ADDR_STATUS, 32'h70000, OK);
    $display("test segments done");
    trg_set(32'h0, 20'h01023, 20'h01023);
    cyc(20'h51023, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    cyc(20'h01024, 1'b0, 1'b0, 1'b1, 1'b0, 0);
    cyc(20'h01023, 1'b0, 1'b0, 1'b0, 1'b0, 0);
    trg_set(32'h8, 20'h12345, 20'h12345);
    cyc(20'h02345, 1'b0, 1'b0, 1'b1, 1'b0, 0);
    cyc(20'h12345, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    trg_set(32'h2, 20'h00120, 20'h00455);
    cyc(20'h00455, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    cyc(20'h00120, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    cyc(20'h00456, 1'b0, 1'b0, 1'b1, 1'b0, 0);
    trg_set(32'h6, 20'h00120, 20'h00455);
    cyc(20'h00456, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    cyc(20'h00300, 1'b0, 1'b0, 1'b1, 1'b0, 0);
    trg_set(32'ha, 20'h10120, 20'h10455);
    cyc(20'h00300, 1'b0, 1'b0, 1'b1, 1'b0, 0);
    cyc(20'h10300, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    trg_set(32'h0, 20'h01200, 20'h01200);
    cyc(20'h00008, 1'b0, 1'b0, 1'b1, 1'b0, 0);
    trg_set(32'h1, 20'h00008, 20'h00008);
    axi_rd(`EDAT_ADDR_TRG_CTRL, 32'h3, OK);
    cyc(20'h01200, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    cyc(20'h00008, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    cyc(20'h00000, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    cyc(20'h01208, 1'b0, 1'b0, 1'b1, 1'b0, 1);
    cyc(20'h01201, 1'b0, 1'b0, 1'b1, 1'b0, 0);
    trg_set(32'h0, 20'h00008, 20'h00008);
    cyc(20'h01200, 1'b0, 1'b0, 1'b1, 1'b0, 0);
    axi_wr(`EDAT_ADDR_TRG_CTRL, 32'h10);
    axi_rd(`EDAT_ADDR_TRG_CTRL, 32'h0, OK);
    cyc(20'h00008, 1'b0, 1'b0, 1'b1, 1'b0, 0);
    $display("test trigger done");
    axi_rd(`EDAT_ADDR_IRQ_STAT, 32'h3, OK);
    chk({31'h0, irq}, 32'h0);
    axi_wr(`EDAT_ADDR_IRQ_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    axi_wr(`EDAT_ADDR_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0);
    axi_rd(`EDAT_ADDR_IRQ_STAT, 32'h2, OK);
    axi_wr(`EDAT_ADDR_IRQ_MASK, 32'h3);
    chk({31'h0, irq}, 32'h1);
    axi_wr(`EDAT_ADDR_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    finish_test();
  end
endmodule // tb
